// ---- hw/cwd_config_decoder.sv ----
// Configuration word store, decoder, reset time-out sequencer and watchdog.
// Assumes all inputs synchronous to core_clk; osc_tick and wdt_rc_tick are
// one-cycle enables marking oscillator input cycles and watchdog RC cycles.
`timescale 1ns/1ps
module cwd_config_decoder
	import cwd_pkg::*;
#(
	parameter bit BIG_MEM = 1'b1,
	parameter int POWERUP_DELAY_TIMER_CYCLES = cwd_pkg::POWERUP_DELAY_TIMER_CYC,
	parameter int OST_CYCLES = cwd_pkg::OST_CYC,
	parameter int WDT_PERIOD = cwd_pkg::WDT_TICKS
) (
	input wire logic core_clk, // Core clock
	input wire logic nrst, // Sync reset, low active
	input wire logic nvm_init, // Cell initialise to erased
	input wire logic prog_mode, // Programming mode
	input wire logic [13:0] prog_addr, // Programming address
	input wire logic prog_wr, // Programming write strobe
	input wire logic [cwd_pkg::CFG_W-1:0] prog_wdata, // Programming data
	output logic [cwd_pkg::CFG_W-1:0] prog_rdata, // Programming read data
	input wire logic por_event, // Power-on detect pulse
	input wire logic brownout_reset_event, // Supply dip pulse
	input wire logic mclr_n, // External reset, low active
	input wire logic sleep_req, // Sleep instruction pulse
	input wire logic irq_wake, // Interrupt wake request
	input wire logic wdt_clear, // Watchdog clear pulse
	input wire logic osc_tick, // Oscillator input cycle
	input wire logic wdt_rc_tick, // Watchdog RC cycle
	output logic [1:0] code_protect_range_field, // Effective protection
	output logic [13:0] protect_lo, // First protected address
	output logic [13:0] protect_hi, // Last protected address
	output logic protect_on, // Some range protected
	output logic brownout_reset_enable_bit, // Brown-out enabled
	output logic powerup_timer_on, // Power-up timer in use
	output logic watchdog_enable_bit, // Watchdog enabled
	output cwd_pkg::cwd_osc_t oscillator_select_field, // Oscillator mode
	output logic core_in_reset, // Core held in reset
	output logic core_sleeping, // Core in sleep
	output logic watchdog_timeout // Watchdog expiry pulse
);
	import cwd_pkg::*;

	initial begin
		if (POWERUP_DELAY_TIMER_CYCLES < 1 || POWERUP_DELAY_TIMER_CYCLES > 4194303 || OST_CYCLES < 1
			|| OST_CYCLES > 4095 || WDT_PERIOD < 1 || WDT_PERIOD > 65535) begin
			$error("cwd_config_decoder: timer parameter out of range");
		end
	end

	// ----------------------------------------
	// Nonvolatile word
	// ----------------------------------------
	// The cell ignores nrst: a device reset must not erase programming.
	logic [CFG_W-1:0] nvm;
	logic [CFG_W-1:0] next_nvm;
	logic cfg_hit;
	logic [CFG_W-1:0] next_rdata;

	assign cfg_hit = prog_mode && (prog_addr == CFG_ADDR);

	always_comb begin
		next_nvm = nvm;
		next_rdata = '0;
		if (nvm_init) begin
			next_nvm = CFG_ERASED;
		end else if (cfg_hit && prog_wr) begin
			next_nvm = nvm & prog_wdata;
		end
		next_nvm[UNIMPL_BIT] = 1'b1;
		// only the programming path sees 2007h
		if (cfg_hit) begin
			next_rdata = nvm;
		end
	end

	always_ff @(posedge core_clk) begin
		nvm <= next_nvm;
		if (!nrst) begin
			prog_rdata <= '0;
		end else begin
			prog_rdata <= next_rdata;
		end
	end

	// ----------------------------------------
	// Decoded settings
	// ----------------------------------------
	logic [1:0] cp_q;
	logic bor_q;
	logic powerup_delay_timer_n_q;
	logic wdt_q;
	cwd_osc_t osc_q;
	logic [1:0] next_cp;
	logic next_bor;
	logic next_powerup_delay_timer_n;
	logic next_wdt;
	cwd_osc_t next_osc;

	always_comb begin
		next_cp = cp_q;
		next_bor = bor_q;
		next_powerup_delay_timer_n = powerup_delay_timer_n_q;
		next_wdt = wdt_q;
		next_osc = osc_q;
		// track the word only while reset is held
		if (!nrst) begin
			// mismatched copies resolve to their AND, at least as strong as the stronger copy
			next_cp = nvm[CP_HI_MSB:CP_HI_LSB] & nvm[CP_LO_MSB:CP_LO_LSB];
			next_bor = nvm[BOR_EN_BIT];
			next_powerup_delay_timer_n = nvm[POWERUP_DELAY_TIMER_N_BIT];
			next_wdt = nvm[WDT_EN_BIT];
			next_osc = cwd_osc_t'(nvm[OSC_MSB:OSC_LSB]);
		end
	end

	always_ff @(posedge core_clk) begin
		cp_q <= next_cp;
		bor_q <= next_bor;
		powerup_delay_timer_n_q <= next_powerup_delay_timer_n;
		wdt_q <= next_wdt;
		osc_q <= next_osc;
	end

	always_comb begin
		protect_lo = BIG_MEM ? BIG_TOP_LO : SML_TOP_LO;
		protect_hi = BIG_MEM ? BIG_END : SML_END;
		case (cp_q)
			CP_HALF: protect_lo = BIG_MEM ? BIG_HALF_LO : SML_HALF_LO;
			CP_ALL: protect_lo = ADDR_ZERO;
			default: protect_lo = BIG_MEM ? BIG_TOP_LO : SML_TOP_LO;
		endcase
	end

	assign code_protect_range_field = cp_q;
	assign protect_on = (cp_q != CP_OFF);
	assign brownout_reset_enable_bit = bor_q;
	assign powerup_timer_on = !powerup_delay_timer_n_q || bor_q;
	assign watchdog_enable_bit = wdt_q;
	assign oscillator_select_field = osc_q;

	// ----------------------------------------
	// Reset sequencer
	// ----------------------------------------
	cwd_state_t state;
	cwd_state_t next_state;
	logic [21:0] powerup_delay_timer_cnt;
	logic [21:0] next_powerup_delay_timer_cnt;
	logic [11:0] ost_cnt;
	logic [11:0] next_ost_cnt;
	logic crystal;
	logic power_evt;
	logic wdt_hit;

	assign crystal = (osc_q != OSC_RC);
	assign power_evt = por_event || (brownout_reset_event && bor_q);

	always_comb begin
		next_state = state;
		next_powerup_delay_timer_cnt = powerup_delay_timer_cnt;
		next_ost_cnt = ost_cnt;
		if (power_evt) begin
			// delay only on power-up or brown-out
			next_powerup_delay_timer_cnt = '0;
			next_ost_cnt = '0;
			next_state = powerup_timer_on ? S_POWERUP_DELAY_TIMER : (crystal ? S_OST : S_RUN);
		end else begin
			case (state)
				S_POWERUP_DELAY_TIMER: begin
					next_powerup_delay_timer_cnt = powerup_delay_timer_cnt + 22'h000001;
					if (powerup_delay_timer_cnt == 22'(POWERUP_DELAY_TIMER_CYCLES - 1)) begin
						// start-up count follows the power-up delay
						next_state = crystal ? S_OST : S_RUN;
					end
				end
				S_OST: begin
					if (osc_tick) begin
						next_ost_cnt = ost_cnt + 12'h001;
						if (ost_cnt == 12'(OST_CYCLES - 1)) begin
							next_state = S_RUN;
						end
					end
				end
				S_RUN: begin
					if (wdt_hit) begin
						next_state = S_WRST;
					end else if (sleep_req && mclr_n) begin
						next_state = S_SLEEP;
					end
				end
				S_SLEEP: begin
					next_ost_cnt = '0;
					if (!mclr_n) begin
						next_state = S_RUN;
					end else if (wdt_hit || irq_wake) begin
						next_state = crystal ? S_OST : S_RUN;
					end
				end
				S_WRST: next_state = S_RUN;
				default: next_state = S_POWERUP_DELAY_TIMER;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state <= S_POWERUP_DELAY_TIMER;
			powerup_delay_timer_cnt <= '0;
			ost_cnt <= '0;
		end else begin
			state <= next_state;
			powerup_delay_timer_cnt <= next_powerup_delay_timer_cnt;
			ost_cnt <= next_ost_cnt;
		end
	end

	assign core_in_reset = !(state == S_RUN || state == S_SLEEP) || !mclr_n;
	assign core_sleeping = (state == S_SLEEP);

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	logic [15:0] wdt_cnt;
	logic [15:0] next_wdt_cnt;

	assign wdt_hit = wdt_q && wdt_rc_tick && (wdt_cnt == 16'(WDT_PERIOD - 1));

	always_comb begin
		next_wdt_cnt = wdt_cnt;
		// the configuration, a clear, core reset or expiry zeroes it; ticks come from its RC
		if (!wdt_q || wdt_clear || core_in_reset || wdt_hit) begin
			next_wdt_cnt = '0;
		end else if (wdt_rc_tick) begin
			next_wdt_cnt = wdt_cnt + 16'h0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			wdt_cnt <= '0;
			watchdog_timeout <= 1'b0;
		end else begin
			wdt_cnt <= next_wdt_cnt;
			watchdog_timeout <= wdt_hit;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_erase;
		@(posedge core_clk) nvm_init |=> (nvm == CFG_ERASED);
	endproperty
	a_erase: assert property (p_erase) else $error("erase not all ones");
	property p_clear_only;
		@(posedge core_clk) !nvm_init |=> ((nvm & ~$past(nvm)) == '0);
	endproperty
	a_clear_only: assert property (p_clear_only) else $error("bit set by write");
	property p_gate;
		@(posedge core_clk) disable iff (!nrst) !prog_mode |=> (prog_rdata == '0);
	endproperty
	a_gate: assert property (p_gate) else $error("word read outside programming");
	property p_hold;
		@(posedge core_clk) disable iff (!nrst) $stable(osc_q) && $stable(cp_q);
	endproperty
	a_hold: assert property (p_hold) else $error("settings moved at run time");
	property p_powerup_delay_timer_force;
		@(posedge core_clk) disable iff (!nrst) bor_q |-> powerup_timer_on;
	endproperty
	a_powerup_delay_timer_force: assert property (p_powerup_delay_timer_force) else $error("brown-out without timer");
	property p_rc_skip;
		@(posedge core_clk) disable iff (!nrst)
			(state == S_SLEEP && irq_wake && mclr_n && !power_evt && !crystal)
			|=> (state == S_RUN);
	endproperty
	a_rc_skip: assert property (p_rc_skip) else $error("start-up timer in RC mode");
	property p_powerup_delay_timer_len;
		@(posedge core_clk) disable iff (!nrst)
			(state == S_POWERUP_DELAY_TIMER) |-> (powerup_delay_timer_cnt < 22'(POWERUP_DELAY_TIMER_CYCLES));
	endproperty
	a_powerup_delay_timer_len: assert property (p_powerup_delay_timer_len) else $error("power-up delay overrun");
	property p_ost_reset;
		@(posedge core_clk) disable iff (!nrst) (state == S_OST) |-> core_in_reset;
	endproperty
	a_ost_reset: assert property (p_ost_reset) else $error("start-up left reset");
	property p_wdt_off;
		@(posedge core_clk) disable iff (!nrst) !wdt_q |=> !watchdog_timeout;
	endproperty
	a_wdt_off: assert property (p_wdt_off) else $error("disabled watchdog fired");
	property p_wake;
		@(posedge core_clk) disable iff (!nrst)
			(state == S_SLEEP && irq_wake && !power_evt) |=> !core_sleeping;
	endproperty
	a_wake: assert property (p_wake) else $error("interrupt did not wake");
	c_powerup_delay_timer_done: cover property (@(posedge core_clk) state == S_POWERUP_DELAY_TIMER ##1 state == S_OST);
	c_run: cover property (@(posedge core_clk) state == S_OST ##1 state == S_RUN);
	c_wdt: cover property (@(posedge core_clk) state == S_RUN ##1 state == S_WRST);
	c_sleep: cover property (@(posedge core_clk) state == S_SLEEP ##1 state == S_OST);
endmodule

// ---- pkg/cwd_pkg.sv ----
// Constants for the configuration word decoder and its reset timers.
// Assumes a single 40 MHz core clock; only the power-up delay count below is derived from it.
package cwd_pkg;
	// ----------------------------------------
	// Configuration word layout
	// ----------------------------------------
	localparam int CFG_W = 14;
	localparam logic [13:0] CFG_ADDR = 14'h2007;
	localparam logic [13:0] CFG_ERASED = 14'h3FFF;
	localparam int CP_HI_MSB = 13;
	localparam int CP_HI_LSB = 12;
	localparam int UNIMPL_BIT = 10;
	localparam int BOR_EN_BIT = 6;
	localparam int CP_LO_MSB = 5;
	localparam int CP_LO_LSB = 4;
	localparam int POWERUP_DELAY_TIMER_N_BIT = 3;
	localparam int WDT_EN_BIT = 2;
	localparam int OSC_MSB = 1;
	localparam int OSC_LSB = 0;
	// ----------------------------------------
	// Code protection ranges
	// ----------------------------------------
	localparam logic [1:0] CP_OFF = 2'h3;
	localparam logic [1:0] CP_TOP = 2'h2;
	localparam logic [1:0] CP_HALF = 2'h1;
	localparam logic [1:0] CP_ALL = 2'h0;
	localparam logic [13:0] ADDR_ZERO = 14'h0000;
	localparam logic [13:0] BIG_TOP_LO = 14'h1F00;
	localparam logic [13:0] BIG_HALF_LO = 14'h1000;
	localparam logic [13:0] BIG_END = 14'h1FFF;
	localparam logic [13:0] SML_TOP_LO = 14'h0F00;
	localparam logic [13:0] SML_HALF_LO = 14'h0800;
	localparam logic [13:0] SML_END = 14'h0FFF;
	// ----------------------------------------
	// Oscillator modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		OSC_LP = 2'h0,
		OSC_XT = 2'h1,
		OSC_HS = 2'h2,
		OSC_RC = 2'h3
	} cwd_osc_t;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int POWERUP_DELAY_TIMER_MS = 72;
	localparam int POWERUP_DELAY_TIMER_CYC = POWERUP_DELAY_TIMER_MS * (CLK_HZ / 1000);
	localparam int OST_CYC = 1024;
	localparam int WDT_TICKS = 2048;
	// ----------------------------------------
	// Reset sequencer states
	// ----------------------------------------
	typedef enum logic [4:0] {
		S_POWERUP_DELAY_TIMER = 5'h01,
		S_OST = 5'h02,
		S_RUN = 5'h04,
		S_SLEEP = 5'h08,
		S_WRST = 5'h10
	} cwd_state_t;
endpackage

// ---- test/cwd_prog_model.sv ----
// Programmer model: drives the programming port of the decoder.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ps
module cwd_prog_model (
	input wire logic core_clk, // Core clock
	output logic prog_mode, // Programming mode
	output logic [13:0] prog_addr, // Programming address
	output logic prog_wr, // Write strobe
	output logic [13:0] prog_wdata, // Write data
	input wire logic [13:0] prog_rdata // Read data
);
	initial begin
		prog_mode = 1'b0;
		prog_addr = 14'h0000;
		prog_wr = 1'b0;
		prog_wdata = 14'h0000;
	end
	// Released lines show the inverse so a stale value never passes
	task automatic release_bus();
		@(posedge core_clk);
		prog_mode <= 1'b0;
		prog_wr <= 1'b0;
		prog_addr <= ~prog_addr;
		prog_wdata <= ~prog_wdata;
	endtask
	// Zero programs a bit; both copies come from one word
	task automatic write(input logic [13:0] a, input logic [13:0] w);
		@(posedge core_clk);
		prog_mode <= 1'b1;
		prog_addr <= a;
		prog_wdata <= w;
		prog_wr <= 1'b1;
		release_bus();
	endtask
	task automatic read(input logic m, input logic [13:0] a, output logic [13:0] r);
		@(posedge core_clk);
		prog_mode <= m;
		prog_addr <= a;
		@(posedge core_clk);
		#1 r = prog_rdata;
		release_bus();
	endtask
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the configuration decoder.
// Assumes short timer counts set by parameter and osc_tick held high.
`timescale 1ns/1ps
module tb_top;
	import cwd_pkg::*;
	localparam int PW = 20;
	localparam int OS = 8;
	// The cell powers up unknown; erase it while reset is held
	logic core_clk = 1'b0, nrst = 1'b0, nvm_init = 1'b1, prog_mode, prog_wr;
	logic [13:0] prog_addr, prog_wdata, prog_rdata, plo, phi, r;
	logic por_event = 1'b0, sleep_req = 1'b0, irq_wake = 1'b0, wdt_rc_tick = 1'b0;
	logic dip_evt = 1'b0, mclr_n = 1'b1, wdt_clear = 1'b0;
	logic [1:0] cpf;
	logic pon, bor, pwr, wen, cir, slp, wto;
	cwd_osc_t osc;
	int miscompares = 0, samples_checked = 0, wdt_hits = 0, n;
	logic [31:0] seed = 32'd32;
	logic [13:0] words [8];
	cwd_config_decoder #(.BIG_MEM(1'b1), .POWERUP_DELAY_TIMER_CYCLES(PW), .OST_CYCLES(OS), .WDT_PERIOD(8))
	cwd_config_decoder_i (.core_clk(core_clk), .nrst(nrst), .nvm_init(nvm_init),
		.prog_mode(prog_mode), .prog_addr(prog_addr), .prog_wr(prog_wr),
		.prog_wdata(prog_wdata), .prog_rdata(prog_rdata), .por_event(por_event),
		.brownout_reset_event(dip_evt), .mclr_n(mclr_n), .sleep_req(sleep_req),
		.irq_wake(irq_wake), .wdt_clear(wdt_clear), .osc_tick(1'b1),
		.wdt_rc_tick(wdt_rc_tick),
		.code_protect_range_field(cpf), .protect_lo(plo), .protect_hi(phi),
		.protect_on(pon), .brownout_reset_enable_bit(bor), .powerup_timer_on(pwr),
		.watchdog_enable_bit(wen), .oscillator_select_field(osc),
		.core_in_reset(cir), .core_sleeping(slp), .watchdog_timeout(wto));
	cwd_prog_model cwd_prog_model_i (.core_clk(core_clk), .prog_mode(prog_mode),
		.prog_addr(prog_addr), .prog_wr(prog_wr), .prog_wdata(prog_wdata),
		.prog_rdata(prog_rdata));
	initial forever #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (wto === 1'b1) wdt_hits <= wdt_hits + 1;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected settle time after power-on: delay plus crystal start-up
	function automatic int exp_start(input logic [13:0] w);
		return ((!w[3] || w[6]) ? PW : 0) + ((w[1:0] != 2'h3) ? OS : 0);
	endfunction
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic pulse_por();
		@(posedge core_clk) por_event <= 1'b1;
		@(posedge core_clk) por_event <= 1'b0;
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ----------------------------------------
	// Load, decode and start-up per word
	// ----------------------------------------
	task automatic apply(input logic [13:0] w);
		logic [1:0] cp;
		@(posedge core_clk) nvm_init <= 1'b1;
		@(posedge core_clk) nvm_init <= 1'b0;
		cwd_prog_model_i.read(1'b1, CFG_ADDR, r);
		chk("erased", r, CFG_ERASED);
		cwd_prog_model_i.write(CFG_ADDR, w);
		cwd_prog_model_i.read(1'b1, CFG_ADDR, r);
		chk("readback", r, w | 14'h0400);
		cwd_prog_model_i.read(1'b0, CFG_ADDR, r);
		chk("run_read", r, 14'h0000);
		cwd_prog_model_i.read(1'b1, 14'h1007, r);
		chk("user_addr", r, 14'h0000);
		@(posedge core_clk) nrst <= 1'b0;
		tick(3);
		nrst <= 1'b1;
		tick(1);
		cp = w[13:12] & w[5:4];
		chk("cp", cpf, cp);
		chk("pon", pon, cp != CP_OFF);
		if (cp != CP_OFF) begin
			chk("plo", plo, cp == CP_TOP ? BIG_TOP_LO : cp == CP_HALF ? BIG_HALF_LO : ADDR_ZERO);
			chk("phi", phi, BIG_END);
		end
		chk("bor", bor, w[6]);
		chk("powerup_delay_timer", pwr, !w[3] || w[6]);
		chk("wdt", wen, w[2]);
		chk("osc", osc, w[1:0]);
		pulse_por();
		#1 n = 0;
		while (cir === 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		chk("start", n >= exp_start(w) && n <= exp_start(w) + 3, 1'b1);
		tick(2);
		chk("held", {cpf, bor, osc}, {cp, w[6], w[1:0]});
	endtask
	initial begin
		words[0] = 14'h3FFB;
		words[1] = 14'h3FF5;
		words[2] = 14'h0000;
		for (int i = 3; i < 8; i++) begin
			seed = lfsr(seed);
			words[i] = seed[13:0];
		end
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		nvm_init <= 1'b0;
		foreach (words[i]) apply(words[i]);
		// Sleep and interrupt wake in RC mode with watchdog enabled
		apply(14'h3FFF);
		@(posedge core_clk) sleep_req <= 1'b1;
		@(posedge core_clk) sleep_req <= 1'b0;
		tick(4);
		chk("asleep", slp, 1'b1);
		@(posedge core_clk) irq_wake <= 1'b1;
		@(posedge core_clk) irq_wake <= 1'b0;
		tick(3);
		chk("woken", slp, 1'b0);
		// External reset during sleep wakes into run, held while low
		@(posedge core_clk) sleep_req <= 1'b1;
		@(posedge core_clk) sleep_req <= 1'b0;
		tick(2);
		chk("asleep2", slp, 1'b1);
		@(posedge core_clk) mclr_n <= 1'b0;
		tick(2);
		chk("mclr_wake", {slp, cir}, 2'b01);
		@(posedge core_clk) mclr_n <= 1'b1;
		tick(1);
		chk("mclr_run", cir, 1'b0);
		// A clear part way through restarts the count
		repeat (5) begin
			@(posedge core_clk) wdt_rc_tick <= 1'b1;
			@(posedge core_clk) wdt_rc_tick <= 1'b0;
		end
		@(posedge core_clk) wdt_clear <= 1'b1;
		@(posedge core_clk) wdt_clear <= 1'b0;
		// Eighth RC tick expires the watchdog
		for (int k = 0; k < 8; k++) begin
			@(posedge core_clk) wdt_rc_tick <= 1'b1;
			@(posedge core_clk) wdt_rc_tick <= 1'b0;
			if (k == 6) chk("wdt_early", wdt_hits, 16'h0000);
		end
		tick(4);
		chk("wdt_fire", wdt_hits, 16'h0001);
		// Supply dip with brown-out on reruns the forced delay
		@(posedge core_clk) dip_evt <= 1'b1;
		@(posedge core_clk) dip_evt <= 1'b0;
		tick(1);
		chk("dip_hold", cir, 1'b1);
		tick(PW - 2);
		chk("dip_len", cir, 1'b1);
		tick(2);
		chk("dip_done", cir, 1'b0);
		apply(14'h3FFB);
		repeat (12) begin
			@(posedge core_clk) wdt_rc_tick <= 1'b1;
			@(posedge core_clk) wdt_rc_tick <= 1'b0;
		end
		tick(4);
		chk("wdt_off", wdt_hits, 16'h0001);
		// Brown-out disabled: a supply dip is ignored
		apply(14'h3FBF);
		@(posedge core_clk) dip_evt <= 1'b1;
		@(posedge core_clk) dip_evt <= 1'b0;
		tick(2);
		chk("dip_off", cir, 1'b0);
		finish_test();
	end
	initial begin
		#400000;
		miscompares++;
		finish_test();
	end
endmodule
